// *** wdg_low_power_ctrl.v ***
// Watchdog downcounter gating across core power modes, with APB registers.
// Overview of operation
// [R1] In SLOW mode the downcounter keeps decrementing at normal speed.
// [R2] In WAIT mode the downcounter keeps decrementing and can reset.
// [R3] Halt with interrupt enable 0 and halt-reset 0 enters Halt, no reset.
// [R4] Entering Halt, counter decrements once more, then stops until interrupt or reset.
// [R5] Wake interrupt from Halt restarts counting after 256 or 4096 clocks.
// [R6] Reset during Halt returns watchdog to disabled unless hardware watchdog.
// [R7] Halt with interrupt enable 0 and halt-reset 1 resets instead.
// [R8] Halt with interrupt enable 1 enters Active Halt, counter stops.
// [R9] Interrupt during Active Halt restarts counting immediately.
// [R10] Reset leaving Active Halt restarts counting after 256 or 4096 clocks.
// [R11] Hardware watchdog option keeps watchdog active, activate bit ignored.
// [R12] Delay choice comes from a configuration bit held stable during halt.
//
// The APB register port and the register offsets were decided locally.
`timescale 1ns/100ps
`include "wdg_lp_consts.vh"
module wdg_low_power_ctrl (
  input wire I_CORE_CLK, // core clock, 100 MHz
  input wire I_RST_B, // async reset, active low
  input wire I_CE, // clock enable, freezes all state when low
  input wire I_SLOW, // core in SLOW mode
  input wire I_WAIT, // core in WAIT mode
  input wire I_HALT_REQ, // pulse: halt instruction executed
  input wire I_EXT_IRQ, // pulse: external wake interrupt
  input wire I_OSC_IRQ, // pulse: oscillator interrupt
  input wire I_SYS_RST, // pulse: system reset leaving a halt
  input wire [31:0] PADDR, // APB address
  input wire PSEL, // APB select
  input wire PENABLE, // APB enable
  input wire PWRITE, // APB direction
  input wire [31:0] PWDATA, // APB write data
  output wire PREADY, // APB ready
  output reg [31:0] PRDATA, // APB read data
  output wire PSLVERR, // APB error
  output reg O_WDG_RESET, // pulse: reset request
  output reg O_HALT_ENTER, // pulse: enter Halt
  output reg O_ACTIVE_HALT_ENTER, // pulse: enter Active Halt
  output reg O_COUNTING, // downcounter is decrementing
  output reg [6:0] O_COUNT, // downcounter value
  output wire O_IRQ // level interrupt
);
  localparam ST_RUN = 4'b0001;
  localparam ST_HALT = 4'b0010;
  localparam ST_AHALT = 4'b0100;
  localparam ST_DELAY = 4'b1000;

  reg [3:0] state_q;
  reg [3:0] state_d;
  reg [31:0] ctrl_q;
  reg [2:0] irq_stat_q;
  reg [2:0] irq_mask_q;
  reg active_q;
  reg halt_dec_q;
  reg dly_start;
  wire dly_busy;
  wire dly_done;
  wire osc_ie;
  wire halt_rst_opt;
  wire hw_wdg;
  wire enabled;
  wire decrement;
  wire expire;
  wire apb_wr;
  wire apb_rd;
  wire addr_ok;
  wire load_wr;
  reg [2:0] irq_set;

  assign osc_ie = ctrl_q[`CTRL_OSC_IE];
  assign halt_rst_opt = ctrl_q[`CTRL_HALT_RST];
  assign hw_wdg = ctrl_q[`CTRL_HW_WDG];
  assign enabled = hw_wdg | active_q; // [R11]

  assign PREADY = 1'b1;
  assign apb_wr = PSEL & PENABLE & PWRITE & I_CE;
  assign apb_rd = PSEL & PENABLE & ~PWRITE;
  assign addr_ok = (PADDR[11:0] == `ADDR_CTRL) | (PADDR[11:0] == `ADDR_STATUS) |
                   (PADDR[11:0] == `ADDR_IRQ_STAT) | (PADDR[11:0] == `ADDR_IRQ_MASK) |
                   (PADDR[11:0] == `ADDR_LOAD);
  assign PSLVERR = PSEL & PENABLE & ~addr_ok;
  assign load_wr = apb_wr & (PADDR[11:0] == `ADDR_LOAD);

  // Counting continues in RUN regardless of SLOW or WAIT; the one extra tick on Halt entry is added.
  assign decrement = enabled & ((state_q == ST_RUN) | halt_dec_q); // [R1] [R2] [R4]
  assign expire = decrement & ~load_wr & (O_COUNT == 7'h40);

  wdg_restart_timer u_timer (
    .i_clk(I_CORE_CLK),
    .i_rst_b(I_RST_B),
    .i_ce(I_CE),
    .i_start(dly_start),
    .i_long(ctrl_q[`CTRL_LONG_DLY]), // [R12]
    .o_busy(dly_busy),
    .o_done(dly_done)
  );

  always @* begin
    state_d = state_q;
    dly_start = 1'b0;
    irq_set = 3'b000;
    case (state_q)
      ST_RUN: begin
        if (I_HALT_REQ) begin
          if (osc_ie) begin
            state_d = ST_AHALT; // [R8]
          end else if (!halt_rst_opt) begin
            state_d = ST_HALT; // [R3]
          end
        end
      end
      ST_HALT: begin
        if (I_EXT_IRQ) begin
          state_d = ST_DELAY; // [R5]
          dly_start = 1'b1;
        end else if (I_SYS_RST) begin
          state_d = ST_RUN; // [R6]
        end
      end
      ST_AHALT: begin
        if (I_SYS_RST) begin
          state_d = ST_DELAY; // [R10]
          dly_start = 1'b1;
        end else if (I_OSC_IRQ | I_EXT_IRQ) begin
          state_d = ST_RUN; // [R9]
          irq_set[`IRQ_RESUME] = 1'b1;
        end
      end
      ST_DELAY: begin
        if (dly_done) begin
          state_d = ST_RUN;
          irq_set[`IRQ_RESUME] = 1'b1;
        end
      end
      default: begin
        state_d = ST_RUN;
      end
    endcase
    if (expire) begin
      irq_set[`IRQ_EXPIRE] = 1'b1;
    end
    if ((state_q == ST_RUN) & I_HALT_REQ & ~osc_ie & halt_rst_opt) begin
      irq_set[`IRQ_HALT_RST] = 1'b1;
    end
  end

  always @(posedge I_CORE_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      state_q <= ST_RUN;
      ctrl_q <= `CTRL_RESET;
      irq_stat_q <= 3'b000;
      irq_mask_q <= 3'b000;
      active_q <= 1'b0;
      halt_dec_q <= 1'b0;
      O_COUNT <= `CNT_RESET;
      O_COUNTING <= 1'b0;
      O_WDG_RESET <= 1'b0;
      O_HALT_ENTER <= 1'b0;
      O_ACTIVE_HALT_ENTER <= 1'b0;
    end else if (I_CE) begin
      state_q <= state_d;
      halt_dec_q <= (state_q == ST_RUN) & (state_d == ST_HALT); // [R4]
      O_HALT_ENTER <= (state_q == ST_RUN) & (state_d == ST_HALT); // [R3]
      O_ACTIVE_HALT_ENTER <= (state_q == ST_RUN) & (state_d == ST_AHALT); // [R8]
      O_WDG_RESET <= irq_set[`IRQ_HALT_RST] | expire; // [R7]
      O_COUNTING <= enabled & (state_d == ST_RUN);
      irq_stat_q <= (irq_stat_q & ~(apb_wr & (PADDR[11:0] == `ADDR_IRQ_STAT) ? PWDATA[2:0] : 3'b000)) | irq_set;
      if (apb_wr & (PADDR[11:0] == `ADDR_CTRL)) begin
        ctrl_q <= {27'h000_0000, PWDATA[4:0]};
        if (PWDATA[`CTRL_ACTIVATE]) begin
          active_q <= 1'b1;
        end
      end
      if (apb_wr & (PADDR[11:0] == `ADDR_IRQ_MASK)) begin
        irq_mask_q <= PWDATA[2:0];
      end
      if ((state_q == ST_HALT) & I_SYS_RST & ~I_EXT_IRQ) begin
        active_q <= 1'b0; // [R6]
        O_COUNT <= `CNT_RESET;
      end else if (load_wr) begin
        O_COUNT <= PWDATA[6:0];
      end else if (expire) begin
        O_COUNT <= `CNT_RESET;
      end else if (decrement) begin
        O_COUNT <= O_COUNT - 7'h01;
      end
    end
  end

  assign O_IRQ = |(irq_stat_q & irq_mask_q);

  always @* begin
    PRDATA = 32'h0000_0000;
    if (apb_rd) begin
      case (PADDR[11:0])
        `ADDR_CTRL: PRDATA = {27'h000_0000, ctrl_q[4:1], active_q};
        `ADDR_STATUS: PRDATA = {23'h00_0000, dly_busy, state_q, O_COUNTING, enabled, 1'b0, 1'b0};
        `ADDR_IRQ_STAT: PRDATA = {29'h0000_0000, irq_stat_q};
        `ADDR_IRQ_MASK: PRDATA = {29'h0000_0000, irq_mask_q};
        `ADDR_LOAD: PRDATA = {25'h000_0000, O_COUNT};
        default: PRDATA = 32'h0000_0000;
      endcase
    end
  end
endmodule

// *** wdg_lp_consts.vh ***
// Constants for the watchdog low-power control block.
`ifndef WDG_LP_CONSTS_VH
`define WDG_LP_CONSTS_VH
`define ADDR_CTRL 12'h000
`define ADDR_STATUS 12'h004
`define ADDR_IRQ_STAT 12'h008
`define ADDR_IRQ_MASK 12'h00C
`define ADDR_LOAD 12'h010
`define CTRL_ACTIVATE 0
`define CTRL_OSC_IE 1
`define CTRL_HALT_RST 2
`define CTRL_HW_WDG 3
`define CTRL_LONG_DLY 4
`define CTRL_RESET 32'h0000_0000
`define CNT_RESET 7'h7F
`define CNT_MSB 6
`define IRQ_EXPIRE 0
`define IRQ_HALT_RST 1
`define IRQ_RESUME 2
`define SHORT_DLY_CYC 13'h0100
`define LONG_DLY_CYC 13'h1000
`endif

// *** wdg_restart_timer.v ***
// Restart delay timer for the watchdog after a halt wake-up.
`timescale 1ns/100ps
`include "wdg_lp_consts.vh"
module wdg_restart_timer (
  input wire i_clk, // core clock
  input wire i_rst_b, // async reset, active low
  input wire i_ce, // clock enable
  input wire i_start, // start pulse
  input wire i_long, // 1: long delay, 0: short delay
  output reg o_busy, // delay running
  output wire o_done // pulse at end of delay
);
  reg [12:0] cnt_q;
  assign o_done = o_busy && (cnt_q == 13'h0001) && i_ce;
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_q <= 13'h0000;
      o_busy <= 1'b0;
    end else if (i_ce) begin
      if (i_start) begin
        cnt_q <= i_long ? `LONG_DLY_CYC : `SHORT_DLY_CYC;
        o_busy <= 1'b1;
      end else if (o_busy) begin
        cnt_q <= cnt_q - 13'h0001;
        if (cnt_q == 13'h0001) begin
          o_busy <= 1'b0;
        end
      end
    end
  end
endmodule

// *** wdg_lp_asserts.sv ***
// Checker for the watchdog low-power control block.
`timescale 1ns/100ps
module wdg_lp_asserts (
  input wire I_CORE_CLK, // clock
  input wire I_RST_B, // reset
  input wire I_SYS_RST, // reset event
  input wire PSEL, // select
  input wire PREADY, // ready
  input wire O_WDG_RESET, // reset out
  input wire O_HALT_ENTER, // halt
  input wire O_ACTIVE_HALT_ENTER, // active halt
  input wire O_COUNTING, // counting
  input wire [6:0] O_COUNT // count
);
  default clocking @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RST_B);
  a_halt_no_rst: assert property (O_HALT_ENTER |-> !O_WDG_RESET) else $error("halt reset");
  a_ahalt_no_rst: assert property (O_ACTIVE_HALT_ENTER |-> !O_WDG_RESET) else $error("ahalt reset");
  a_one_halt: assert property (!(O_HALT_ENTER && O_ACTIVE_HALT_ENTER)) else $error("two halts");
  a_halt_stops: assert property (O_HALT_ENTER |-> ##[0:2] !O_COUNTING) else $error("halt counts");
  a_ahalt_stops: assert property (O_ACTIVE_HALT_ENTER |-> ##[0:1] !O_COUNTING) else $error("ahalt counts");
  a_count_frozen: assert property (!O_COUNTING [*3] ##0 !$past(PSEL) && !$past(I_SYS_RST) |-> $stable(O_COUNT))
    else $error("count moved");
  a_rst_pulse: assert property (O_WDG_RESET |=> !O_WDG_RESET) else $error("reset held");
  a_zero_wait: assert property (PSEL |-> PREADY) else $error("wait state");
endmodule
bind wdg_low_power_ctrl wdg_lp_asserts chk_u (.*);

// *** wdg_core_model.sv ***
// Core power-mode controller model: mode levels and event pulses.
`timescale 1ns/100ps
module wdg_core_model (
  input wire logic i_clk, // clock
  output logic o_slow = 1'b0, // slow mode
  output logic o_wait = 1'b0, // wait mode
  output logic [3:0] o_ev = 4'h0 // halt, ext irq, osc irq, reset
);
  task mode(input logic s, input logic w);
    o_slow <= s;
    o_wait <= w;
  endtask
  // Called just after a rising edge; the pulse lasts one cycle.
  task ev(input int k);
    o_ev <= 4'h1 << k;
    @(posedge i_clk);
    o_ev <= 4'h0;
  endtask
endmodule

// *** testbench.sv ***
// Testbench for the watchdog low-power control block.
`timescale 1ns/100ps
`include "wdg_lp_consts.vh"
module testbench;
  logic clk = 1'b0, rst_b = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, ce = 1'b1;
  logic rde, slow, wt, rdy, err, wrst, hen, ahen, on, irq;
  logic [31:0] pa = 32'h0000_0000, pwd = 32'h0000_0000, prd, rdv;
  logic [3:0] ev;
  logic [6:0] cnt, c0;
  int err_count = 0, checks_done = 0;
  always #5 clk = ~clk;
  wdg_core_model core_u (.i_clk(clk), .o_slow(slow), .o_wait(wt), .o_ev(ev));
  wdg_low_power_ctrl dut_u (.I_CORE_CLK(clk), .I_RST_B(rst_b), .I_CE(ce), .I_SLOW(slow), .I_WAIT(wt),
    .I_HALT_REQ(ev[0]), .I_EXT_IRQ(ev[1]), .I_OSC_IRQ(ev[2]), .I_SYS_RST(ev[3]), .PADDR(pa), .PSEL(psel),
    .PENABLE(pen), .PWRITE(pwr), .PWDATA(pwd), .PREADY(rdy), .PRDATA(prd), .PSLVERR(err), .O_WDG_RESET(wrst),
    .O_HALT_ENTER(hen), .O_ACTIVE_HALT_ENTER(ahen), .O_COUNTING(on), .O_COUNT(cnt), .O_IRQ(irq));
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task stop_test;
    if (err_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    pa <= {20'h0_0000, a};
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (rdy !== 1'b1);
    rdv = prd;
    rde = err;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  task halt(input logic [31:0] c, input logic [2:0] ef);
    logic [2:0] f;
    bus(1'b1, `ADDR_LOAD, 32'h0000_007F);
    bus(1'b1, `ADDR_CTRL, c);
    core_u.ev(0);
    f = 3'h0;
    repeat (3) begin
      @(posedge clk);
      f |= {wrst, hen, ahen};
    end
    chk("halt outcome", ef, f);
  endtask
  task wake(input int k, input int lo, input int hi);
    int n;
    core_u.ev(k);
    n = 0;
    while (on !== 1'b1 && n < 5000) begin
      @(posedge clk);
      n++;
    end
    chk("restart delay", 1, n >= lo && n <= hi);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    bus(1'b0, `ADDR_CTRL, 32'h0000_0000);
    chk("ctrl", 32'h0000_0000, rdv);
    bus(1'b0, 12'h020, 32'h0000_0000);
    chk("slverr", 1, rde);
    bus(1'b1, `ADDR_IRQ_MASK, 32'h0000_0007);
    bus(1'b1, `ADDR_CTRL, 32'h0000_0001);
    core_u.mode(1'b1, 1'b1);
    repeat (2) @(posedge clk);
    c0 = cnt;
    repeat (4) @(posedge clk);
    chk("count", c0 - 7'h04, cnt);
    ce <= 1'b0;
    @(posedge clk);
    c0 = cnt;
    repeat (3) @(posedge clk);
    chk("frozen count", c0, cnt);
    ce <= 1'b1;
    halt(32'h0000_0001, 3'h2);
    wake(1, 255, 258);
    halt(32'h0000_0011, 3'h2);
    wake(1, 4095, 4098);
    halt(32'h0000_0005, 3'h4);
    chk("irq", 1, irq);
    bus(1'b1, `ADDR_IRQ_STAT, 32'h0000_0007);
    chk("irq clear", 0, irq);
    bus(1'b1, `ADDR_IRQ_MASK, 32'h0000_0000);
    halt(32'h0000_0005, 3'h4);
    chk("irq mask", 0, irq);
    bus(1'b0, `ADDR_IRQ_STAT, 32'h0000_0000);
    chk("halt rst flag", 32'h0000_0002, rdv);
    halt(32'h0000_0003, 3'h1);
    chk("stopped", 0, on);
    wake(2, 0, 2);
    halt(32'h0000_0003, 3'h1);
    wake(3, 255, 258);
    halt(32'h0000_0001, 3'h2);
    core_u.ev(3);
    bus(1'b0, `ADDR_CTRL, 32'h0000_0000);
    chk("active", 0, rdv[0]);
    halt(32'h0000_0008, 3'h2);
    core_u.ev(3);
    bus(1'b0, `ADDR_STATUS, 32'h0000_0000);
    chk("hw enabled", 1, rdv[2]);
    stop_test;
  end
  initial begin
    #300_000;
    err_count++;
    stop_test;
  end
endmodule
